// file: pagp_defines.svh
// offsets, field positions, reset values and response codes of the port a gpio block
`ifndef PAGP_DEFINES_SVH
`define PAGP_DEFINES_SVH

// -------------------------------------------------
// bus widths and register offsets
// -------------------------------------------------
`define PAGP_ADDR_W      8
`define PAGP_OFS_DIR     8'h00
`define PAGP_OFS_LEVEL   8'h04
`define PAGP_OFS_LATCH   8'h08
`define PAGP_OFS_ANA     8'h0c
`define PAGP_OFS_CMP     8'h10
`define PAGP_OFS_REF     8'h14
`define PAGP_OFS_OSC     8'h18

// -------------------------------------------------
// reset values
// -------------------------------------------------
`define PAGP_RST_DIR     8'hff
`define PAGP_RST_LATCH   8'h00
`define PAGP_RST_ANA     8'h2f
`define PAGP_RST_CMP     3'h0
`define PAGP_RST_REF     1'h0
`define PAGP_RST_OSC     3'h1

// -------------------------------------------------
// fields
// -------------------------------------------------
`define PAGP_ANA_MASK    8'h2f
`define PAGP_CMP_ON      0
`define PAGP_CMP_C1_PIN  1
`define PAGP_CMP_C2_PIN  2
`define PAGP_CMP_C1_STAT 6
`define PAGP_CMP_C2_STAT 7
`define PAGP_REF_EN      0
`define PAGP_PIN_REF     2
`define PAGP_PIN_TMR     4
`define PAGP_PIN_C1      4
`define PAGP_PIN_C2      5
`define PAGP_PIN_OSC2    6
`define PAGP_PIN_OSC1    7
`define PAGP_CMP_IN_MASK 8'h0f

// -------------------------------------------------
// bus responses
// -------------------------------------------------
`define PAGP_RESP_OKAY   2'h0
`define PAGP_RESP_SLVERR 2'h2

`endif

// file: pagp_pkg.sv
// types of the port a gpio block
package pagp_pkg;

  typedef enum logic [2:0] {
    rc_osc_io_mode,
    internal_osc_io_mode,
    ext_clock_io_mode,
    rc_clkout_mode,
    internal_osc_clkout_mode,
    ext_clock_clkout_mode,
    crystal_mode
  } pagp_osc_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] level;
  } pagp_sync_t;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] latch;
    logic [7:0] ana;
    logic [2:0] cmp;
    logic       ref_en;
    pagp_osc_t  osc;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
    logic       aw_got;
    logic [7:0] aw_addr;
    logic       w_got;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pagp_state_t;

endpackage

// file: pagp_sync_if.sv
// carrier between the top and the pin synchroniser
`timescale 1ns/1ps
interface pagp_sync_if;
  logic [7:0] raw;
  logic [7:0] level;
  modport owner (output raw, input level);
  modport filt  (input raw, output level);
endinterface

// file: pagp_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "pagp_defines.svh"
module pagp_sync
  import pagp_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // pins in, filtered levels out
  pagp_sync_if.filt sif
);

  pagp_sync_t st_r;
  pagp_sync_t st_nxt;

  // -------------------------------------------------
  // per bit stages
  // -------------------------------------------------
  // s1 is read only by s2; a level counts once s2 and s3 agree
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = sif.raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 8; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
        st_nxt.level[i] = st_r.s3[i];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sif.level = st_r.level;

endmodule

// file: pagp_port_a_gpio.sv
// port a gpio: axi4-lite register slave, pin muxing and driver control
`timescale 1ns/1ps
`include "pagp_defines.svh"
module pagp_port_a_gpio
  import pagp_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // port pins
  input  wire logic [7:0]  pin_in,
  output logic [7:0]       pin_out,
  output logic [7:0]       pin_oe_n,
  // shared peripherals
  input  wire logic        comparator1_out,
  input  wire logic        comparator2_out,
  output logic             timer0_ext_clock_in,
  output logic             comparator_ref_en,
  output logic             comparators_on
);

  pagp_state_t st_r;
  pagp_state_t st_nxt;

  // -------------------------------------------------
  // pin synchroniser
  // -------------------------------------------------
  pagp_sync_if sif ();

  assign sif.raw = pin_in;

  pagp_sync u_sync (
    .mclk (mclk),
    .rst  (rst),
    .sif  (sif)
  );

  // -------------------------------------------------
  // pin ownership
  // -------------------------------------------------
  logic       pin6_io;
  logic       pin7_io;
  logic [7:0] osc_keep;
  logic [7:0] din_en;
  logic [7:0] drive;
  logic [7:0] dout;
  logic       c1_on_pin;
  logic       c2_on_pin;

  always_comb
  begin
    pin6_io = (st_r.osc == rc_osc_io_mode) ||
              (st_r.osc == internal_osc_io_mode) ||
              (st_r.osc == ext_clock_io_mode);
    // bit 7 is the clock input in every mode that uses an outside source
    pin7_io = (st_r.osc == internal_osc_io_mode) ||
              (st_r.osc == internal_osc_clkout_mode);
    osc_keep = {pin7_io, pin6_io, 6'h3f};
  end

  // comparator outputs only reach a pin while the comparators run
  assign c1_on_pin = st_r.cmp[`PAGP_CMP_ON] & st_r.cmp[`PAGP_CMP_C1_PIN];
  assign c2_on_pin = st_r.cmp[`PAGP_CMP_ON] & st_r.cmp[`PAGP_CMP_C2_PIN];

  always_comb
  begin
    // analog selection gates only the input path
    din_en = ~st_r.ana & osc_keep;
    if (st_r.cmp[`PAGP_CMP_ON])
      din_en = din_en & ~`PAGP_CMP_IN_MASK;
    if (st_r.ref_en)
      din_en[`PAGP_PIN_REF] = 1'b0;
    // direction decides the driver, analog or not; oscillator mode and reference enable can also release a pin
    drive = ~st_r.dir & osc_keep;
    if (st_r.ref_en)
      drive[`PAGP_PIN_REF] = 1'b0;
    dout = st_r.latch;
    if (c1_on_pin)
      dout[`PAGP_PIN_C1] = comparator1_out;
    if (c2_on_pin)
      dout[`PAGP_PIN_C2] = comparator2_out;
  end

  // -------------------------------------------------
  // bus handshake terms
  // -------------------------------------------------
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic       aw_ok;
  logic       w_ok;
  logic       do_write;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_lane0;

  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;

  assign aw_hs    = s_axi_awvalid && s_axi_awready;
  assign w_hs     = s_axi_wvalid && s_axi_wready;
  assign ar_hs    = s_axi_arvalid && s_axi_arready;
  assign aw_ok    = st_r.aw_got || aw_hs;
  assign w_ok     = st_r.w_got || w_hs;
  assign do_write = aw_ok && w_ok && !st_r.bvalid;
  assign wr_addr  = st_r.aw_got ? st_r.aw_addr : s_axi_awaddr;
  assign wr_data  = st_r.w_got ? st_r.w_data : s_axi_wdata[7:0];
  assign wr_lane0 = st_r.w_got ? st_r.w_lane0 : s_axi_wstrb[0];

  // -------------------------------------------------
  // read mux
  // -------------------------------------------------
  logic [7:0] rd_byte;
  logic       rd_hit;

  always_comb
  begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      `PAGP_OFS_DIR:
        rd_byte = st_r.dir & osc_keep;
      `PAGP_OFS_LEVEL:
        rd_byte = sif.level & din_en;
      `PAGP_OFS_LATCH:
        rd_byte = st_r.latch & osc_keep;
      `PAGP_OFS_ANA:
        rd_byte = st_r.ana;
      `PAGP_OFS_CMP:
        rd_byte = {comparator2_out, comparator1_out, 3'h0, st_r.cmp};
      `PAGP_OFS_REF:
        rd_byte = {7'h00, st_r.ref_en};
      `PAGP_OFS_OSC:
        rd_byte = {5'h00, st_r.osc};
      default:
        rd_hit = 1'b0;
    endcase
  end

  // -------------------------------------------------
  // write decode
  // -------------------------------------------------
  logic wr_hit;

  always_comb
  begin
    unique case (wr_addr)
      `PAGP_OFS_DIR,
      `PAGP_OFS_LEVEL,
      `PAGP_OFS_LATCH,
      `PAGP_OFS_ANA,
      `PAGP_OFS_CMP,
      `PAGP_OFS_REF,
      `PAGP_OFS_OSC:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  // -------------------------------------------------
  // next state
  // -------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;

    // write channels: hold a half until its partner comes
    if (aw_hs && !do_write)
    begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (w_hs && !do_write)
    begin
      st_nxt.w_got   = 1'b1;
      st_nxt.w_data  = s_axi_wdata[7:0];
      st_nxt.w_lane0 = s_axi_wstrb[0];
    end

    if (do_write)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = wr_hit ? `PAGP_RESP_OKAY : `PAGP_RESP_SLVERR;
      // registers are one byte wide, so only lane 0 carries data
      if (wr_lane0)
      begin
        unique case (wr_addr)
          `PAGP_OFS_DIR:
            st_nxt.dir = wr_data;
          `PAGP_OFS_LEVEL,
          `PAGP_OFS_LATCH:
            st_nxt.latch = wr_data;
          `PAGP_OFS_ANA:
            st_nxt.ana = wr_data & `PAGP_ANA_MASK;
          `PAGP_OFS_CMP:
            st_nxt.cmp = wr_data[2:0];
          `PAGP_OFS_REF:
            st_nxt.ref_en = wr_data[`PAGP_REF_EN];
          `PAGP_OFS_OSC:
            // code 7 is unused and falls back to the crystal mode
            st_nxt.osc = (wr_data[2:0] == 3'h7) ? crystal_mode : pagp_osc_t'(wr_data[2:0]);
          default:
            st_nxt.bresp = `PAGP_RESP_SLVERR;
        endcase
      end
    end
    else if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end

    // read channel
    if (ar_hs)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = {24'h000000, rd_byte};
      st_nxt.rresp  = rd_hit ? `PAGP_RESP_OKAY : `PAGP_RESP_SLVERR;
    end
    else if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end

    // pin drivers are registered so the pads never see decode glitches
    st_nxt.pin_out  = dout & drive;
    st_nxt.pin_oe_n = ~drive;
  end

  // -------------------------------------------------
  // state register
  // -------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_r          <= '0;
      st_r.dir      <= `PAGP_RST_DIR;
      st_r.latch    <= `PAGP_RST_LATCH;
      st_r.ana      <= `PAGP_RST_ANA;
      st_r.cmp      <= `PAGP_RST_CMP;
      st_r.ref_en   <= `PAGP_RST_REF;
      st_r.osc      <= pagp_osc_t'(`PAGP_RST_OSC);
      st_r.pin_oe_n <= 8'hff;
      st_r.bresp    <= `PAGP_RESP_OKAY;
      st_r.rresp    <= `PAGP_RESP_OKAY;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // -------------------------------------------------
  // outputs
  // -------------------------------------------------
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp  = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata  = st_r.rdata;
  assign s_axi_rresp  = st_r.rresp;
  assign pin_out      = st_r.pin_out;
  assign pin_oe_n     = st_r.pin_oe_n;

  // schmitt input goes to the timer whatever the direction is
  assign timer0_ext_clock_in = sif.level[`PAGP_PIN_TMR];
  assign comparator_ref_en   = st_r.ref_en;
  assign comparators_on      = st_r.cmp[`PAGP_CMP_ON];

endmodule

// file: pagp_assertions.sv
// concurrent checks on the port a gpio top ports
`timescale 1ns/1ps
module pagp_chk
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // pins and shared functions
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe_n,
  input wire logic        timer0_ext_clock_in,
  input wire logic        comparator_ref_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // the pin filter holds reset values for a while, so settle checks wait
  logic [3:0] up_r;
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      up_r <= 4'h0;
    else if (up_r != 4'hf)
      up_r <= up_r + 4'h1;

  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_wr_ans;
    s_wr |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write response");
  property p_rd_ans;
    s_rd |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read data");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write response repeated");
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_once: assert property (p_r_once) else $error("read data repeated");
  property p_b_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken during response");
  property p_r_busy;
    s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_r_busy: assert property (p_r_busy) else $error("bad read data or ready");
  property p_hiz;
    (pin_out & pin_oe_n) == 8'h00;
  endproperty
  a_hiz: assert property (p_hiz) else $error("data on released pin");
  property p_ref;
    comparator_ref_en && $past(comparator_ref_en) |-> pin_oe_n[2];
  endproperty
  a_ref: assert property (p_ref) else $error("pin 2 driven with reference on");
  property p_tmr;
    (up_r == 4'hf && $stable(pin_in[4])) [*6] |-> timer0_ext_clock_in == pin_in[4];
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer input not following pin 4");
endmodule

bind pagp_port_a_gpio pagp_chk u_chk (.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .pin_in, .pin_out, .pin_oe_n, .timer0_ext_clock_in, .comparator_ref_en);

// file: pagp_pin_model.sv
// far-side model of the eight port pins
`timescale 1ns/1ps
module pagp_pin_model
(
  // clock
  input  wire logic       mclk,
  // design side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  // external drivers, weaker than the port
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  // resolved pin level
  output logic      [7:0] pin_in
);
  // no pulls on these pins: a floating pin wanders instead of holding
  logic [7:0] float_r = 8'h55;
  always_ff @(posedge mclk)
    float_r <= ~float_r;
  always_comb
    pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) | (pin_oe_n & ~ext_en & float_r);
endmodule

// file: port_a_gpio_bench.sv
// self-checking bench for the port a gpio block
`timescale 1ns/1ps
module port_a_gpio_bench;
  typedef struct packed { logic wr; logic [7:0] a; logic [7:0] v; logic [1:0] r; } pagp_row_t;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, c1, c2, tmr, refe, cmpon;
  logic [7:0]  awa, ara, pin_in, pout, oen, ext;
  logic [31:0] wd, rd;
  logic [1:0]  bre, rre;
  logic [3:0]  ws;
  int          err_count = 0;
  int          checks = 0;
  pagp_row_t   rows [19];

  always #25 mclk = ~mclk;

  pagp_port_a_gpio uut (.mclk(mclk), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bre), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
    .s_axi_rresp(rre), .pin_in(pin_in), .pin_out(pout), .pin_oe_n(oen), .comparator1_out(c1),
    .comparator2_out(c2), .timer0_ext_clock_in(tmr), .comparator_ref_en(refe), .comparators_on(cmpon));
  pagp_pin_model pins (.mclk(mclk), .pin_out(pout), .pin_oe_n(oen), .ext_val(ext), .ext_en(8'hff),
    .pin_in(pin_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wt;
    repeat (8) @(posedge mclk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= {24'h0, d};
    br <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
    end
    while (!bv && n < 50);
    br <= 1'b0;
    if (!bv)
    begin
      err_count++;
      summarize;
    end
    chk({30'h0, bre}, {30'h0, er}, "write response");
  endtask

  task automatic axr(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end
    while (!rv && n < 50);
    rr <= 1'b0;
    if (!rv)
    begin
      err_count++;
      summarize;
    end
    chk(rd, {24'h0, e}, "read data");
    chk({30'h0, rre}, {30'h0, er}, "read response");
  endtask

  initial
  begin
    {awv, wv, br, arv, rr, c1, c2} = 7'h00;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0;
    ws = 4'hf;
    ext = 8'hbf;
    rows = '{'{1'b0, 8'h00, 8'hff, 2'h0}, '{1'b0, 8'h08, 8'h00, 2'h0},
      '{1'b0, 8'h0c, 8'h2f, 2'h0}, '{1'b0, 8'h10, 8'h00, 2'h0},
      '{1'b0, 8'h14, 8'h00, 2'h0}, '{1'b0, 8'h18, 8'h01, 2'h0},
      '{1'b0, 8'h04, 8'h90, 2'h0}, '{1'b1, 8'h0c, 8'h00, 2'h0},
      '{1'b1, 8'h18, 8'h00, 2'h0}, '{1'b1, 8'h08, 8'ha5, 2'h0},
      '{1'b0, 8'h08, 8'h25, 2'h0}, '{1'b1, 8'h18, 8'h01, 2'h0},
      '{1'b0, 8'h08, 8'ha5, 2'h0}, '{1'b1, 8'h04, 8'h2d, 2'h0},
      '{1'b0, 8'h08, 8'h2d, 2'h0}, '{1'b1, 8'h00, 8'hf0, 2'h0},
      '{1'b0, 8'h04, 8'hbd, 2'h0}, '{1'b1, 8'h1c, 8'h00, 2'h2},
      '{1'b0, 8'h1c, 8'h00, 2'h2}};
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      wt;
      if (rows[i].wr)
        axw(rows[i].a, rows[i].v, rows[i].r);
      else
        axr(rows[i].a, rows[i].v, rows[i].r);
    end
    // analog on a driven pin: input reads zero, driver keeps latch
    axw(8'h0c, 8'h01, 2'h0);
    wt;
    axr(8'h04, 8'hbc, 2'h0);
    chk({30'h0, oen[0], pout[0]}, 32'h1, "pin 0 drive");
    @(posedge mclk);
    ext <= 8'haf;
    wt;
    chk({31'h0, tmr}, 32'h0, "timer input");
    axr(8'h04, 8'hac, 2'h0);
    // comparators on cut the low nibble, outputs beat latch data
    axw(8'h10, 8'h01, 2'h0);
    wt;
    axr(8'h04, 8'ha0, 2'h0);
    chk({31'h0, cmpon}, 32'h1, "comparators on");
    axw(8'h00, 8'hc0, 2'h0);
    axw(8'h10, 8'h07, 2'h0);
    c1 <= 1'b1;
    wt;
    chk({30'h0, pout[5:4]}, 32'h1, "comparator pins");
    c1 <= 1'b0;
    c2 <= 1'b1;
    wt;
    chk({30'h0, pout[5:4]}, 32'h2, "comparator pins");
    axr(8'h10, 8'h87, 2'h0);
    // reference output takes pin 2 away from the port
    axw(8'h14, 8'h01, 2'h0);
    wt;
    chk({31'h0, oen[2]}, 32'h1, "pin 2 released");
    chk({31'h0, refe}, 32'h1, "reference enable");
    // a write with lane 0 off leaves the byte-wide latch alone
    ws <= 4'he;
    axw(8'h08, 8'h00, 2'h0);
    ws <= 4'hf;
    axr(8'h08, 8'h2d, 2'h0);
    // oscillator modes decide whether bits 6 and 7 exist
    for (int m = 0; m < 8; m++)
    begin
      axw(8'h18, 8'(m), 2'h0);
      axr(8'h00, {(m == 1 || m == 4), (m < 3), 6'h00}, 2'h0);
      axr(8'h18, (m == 7) ? 8'h06 : 8'(m), 2'h0);
    end
    // reset in mid-run brings back the power-on configuration
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({16'h0, oen, pout}, 32'hff00, "reset pins");
    chk({27'h0, awr, wrd, arr, bv, rv}, 32'h1c, "reset bus");
    chk({29'h0, refe, cmpon, tmr}, 32'h0, "reset shared");
    rst <= 1'b0;
    wt;
    axr(8'h00, 8'hff, 2'h0);
    axr(8'h0c, 8'h2f, 2'h0);
    axr(8'h18, 8'h01, 2'h0);
    wt;
    axr(8'h04, 8'h80, 2'h0);
    summarize;
  end
endmodule
